// >>> hdl/ipl_regs.v
// interrupt priority registers 0 to 4 with per-source level decode
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "ipl_map.vh"
module ipl_regs (
   clk,
   rst,
   addr,
   wdata,
   wr,
   rd,
   rdata,
   dbg_pending,
   per_pending,
   dbg_request,
   dbg_level,
   per_request,
   per_level
);
   input wire clk;
   input wire rst;
   input wire [2:0] addr;
   input wire [15:0] wdata;
   input wire wr;
   input wire rd;
   output reg [15:0] rdata;
   // debug order: breakpoint, step, receive, transmit, trace
   input wire [`IPL_NUM_DEBUG-1:0] dbg_pending;
   // peripheral order: flash empty, done, error, pll, lv, pin b, pin a,
   // port d, e, f, can buffer, wakeup, error, bus off, spi0 rx, spi1 tx,
   // spi1 rx, port a, port b, port c
   input wire [`IPL_NUM_PERIPH-1:0] per_pending;
   output reg [`IPL_NUM_DEBUG-1:0] dbg_request;
   output reg [2*`IPL_NUM_DEBUG-1:0] dbg_level;
   output reg [`IPL_NUM_PERIPH-1:0] per_request;
   output reg [2*`IPL_NUM_PERIPH-1:0] per_level;

   // ----------------------------------------
   // register file
   // ----------------------------------------
   wire [15:0] debug_break_priority;
   wire [15:0] debug_xfer_priority;
   wire [15:0] system_event_priority;
   wire [15:0] port_can_priority;
   wire [15:0] serial_port_priority;

   // ----------------------------------------
   // register select and write enables
   // ----------------------------------------
   // one select per register; an unmapped index selects nothing, so a write
   // there is dropped and a read there returns zero
   wire sel_break;
   wire sel_xfer;
   wire sel_system;
   wire sel_port;
   wire sel_serial;

   wire wr_break;
   wire wr_xfer;
   wire wr_system;
   wire wr_port;
   wire wr_serial;

   assign sel_break = (addr == `IPL_OFS_BREAK);
   assign sel_xfer = (addr == `IPL_OFS_XFER);
   assign sel_system = (addr == `IPL_OFS_SYSTEM);
   assign sel_port = (addr == `IPL_OFS_PORT);
   assign sel_serial = (addr == `IPL_OFS_SERIAL);

   assign wr_break = wr & sel_break;
   assign wr_xfer = wr & sel_xfer;
   assign wr_system = wr & sel_system;
   assign wr_port = wr & sel_port;
   assign wr_serial = wr & sel_serial;

   ipl_reg16 #(.MASK(`IPL_MASK_BREAK)) u_break ( // R5
      .clk(clk),
      .rst(rst),
      .wr(wr_break),
      .wdata(wdata),
      .q(debug_break_priority)
   );
   ipl_reg16 #(.MASK(`IPL_MASK_XFER)) u_xfer ( // R6
      .clk(clk),
      .rst(rst),
      .wr(wr_xfer),
      .wdata(wdata),
      .q(debug_xfer_priority)
   );
   ipl_reg16 #(.MASK(`IPL_MASK_SYSTEM)) u_system ( // R7 R8
      .clk(clk),
      .rst(rst),
      .wr(wr_system),
      .wdata(wdata),
      .q(system_event_priority)
   );
   ipl_reg16 #(.MASK(`IPL_MASK_PORT)) u_port ( // R9 R10
      .clk(clk),
      .rst(rst),
      .wr(wr_port),
      .wdata(wdata),
      .q(port_can_priority)
   );
   ipl_reg16 #(.MASK(`IPL_MASK_SERIAL)) u_serial ( // R11 R12 R13
      .clk(clk),
      .rst(rst),
      .wr(wr_serial),
      .wdata(wdata),
      .q(serial_port_priority)
   );

   // ----------------------------------------
   // read port
   // ----------------------------------------
   reg [15:0] next_rdata;
   always @* begin
      next_rdata = 16'h0000; // R4
      if (sel_break) begin
         next_rdata = debug_break_priority;
      end
      if (sel_xfer) begin
         next_rdata = debug_xfer_priority;
      end
      if (sel_system) begin
         next_rdata = system_event_priority;
      end
      if (sel_port) begin
         next_rdata = port_can_priority;
      end
      if (sel_serial) begin
         next_rdata = serial_port_priority;
      end
   end

   // read data stand only in the cycle after the strobe, zero otherwise
   always @(posedge clk) begin
      if (rst) begin
         rdata <= 16'h0000;
      end else if (rd) begin
         rdata <= next_rdata;
      end else begin
         rdata <= 16'h0000;
      end
   end

   // ----------------------------------------
   // field gathering
   // ----------------------------------------
   // every source owns the two-bit slice [2i+1:2i] of its vector
   wire [2*`IPL_NUM_DEBUG-1:0] dbg_fields;
   wire [2*`IPL_NUM_PERIPH-1:0] per_fields;

   // ----------------------------------------
   // debug break register fields
   // ----------------------------------------
   wire [1:0] breakpoint_zero_level;
   wire [1:0] step_counter_level;
   assign breakpoint_zero_level = debug_break_priority[`IPL_POS_BKPT+:2]; // R5
   assign step_counter_level = debug_break_priority[`IPL_POS_STEP+:2]; // R5
   assign dbg_fields[9:8] = breakpoint_zero_level;
   assign dbg_fields[7:6] = step_counter_level;

   // ----------------------------------------
   // debug transfer register fields
   // ----------------------------------------
   wire [1:0] debug_receive_full_level;
   wire [1:0] debug_transmit_empty_level;
   wire [1:0] trace_buffer_level;
   assign debug_receive_full_level = debug_xfer_priority[`IPL_POS_DRX+:2]; // R6
   assign debug_transmit_empty_level = debug_xfer_priority[`IPL_POS_DTX+:2]; // R6
   assign trace_buffer_level = debug_xfer_priority[`IPL_POS_TRACE+:2]; // R6
   assign dbg_fields[5:4] = debug_receive_full_level;
   assign dbg_fields[3:2] = debug_transmit_empty_level;
   assign dbg_fields[1:0] = trace_buffer_level;

   // ----------------------------------------
   // system event register fields
   // ----------------------------------------
   wire [1:0] flash_buffers_empty_level;
   wire [1:0] flash_command_done_level;
   wire [1:0] flash_error_level;
   wire [1:0] pll_unlock_level;
   wire [1:0] low_voltage_level;
   wire [1:0] ext_pin_b_level;
   wire [1:0] ext_pin_a_level;
   assign flash_buffers_empty_level = system_event_priority[`IPL_POS_FLEMPTY+:2]; // R7
   assign flash_command_done_level = system_event_priority[`IPL_POS_FLDONE+:2]; // R7
   assign flash_error_level = system_event_priority[`IPL_POS_FLERR+:2]; // R7
   assign pll_unlock_level = system_event_priority[`IPL_POS_PLL+:2]; // R8
   assign low_voltage_level = system_event_priority[`IPL_POS_LVD+:2]; // R8
   assign ext_pin_b_level = system_event_priority[`IPL_POS_PINB+:2]; // R8
   assign ext_pin_a_level = system_event_priority[`IPL_POS_PINA+:2]; // R8
   assign per_fields[39:38] = flash_buffers_empty_level;
   assign per_fields[37:36] = flash_command_done_level;
   assign per_fields[35:34] = flash_error_level;
   assign per_fields[33:32] = pll_unlock_level;
   assign per_fields[31:30] = low_voltage_level;
   assign per_fields[29:28] = ext_pin_b_level;
   assign per_fields[27:26] = ext_pin_a_level;

   // ----------------------------------------
   // port and bus register fields
   // ----------------------------------------
   wire [1:0] port_d_level;
   wire [1:0] port_e_level;
   wire [1:0] port_f_level;
   wire [1:0] can_msg_buffer_level;
   wire [1:0] can_wakeup_level;
   wire [1:0] can_error_level;
   wire [1:0] can_bus_off_level;
   assign port_d_level = port_can_priority[`IPL_POS_PD+:2]; // R9
   assign port_e_level = port_can_priority[`IPL_POS_PE+:2]; // R9
   assign port_f_level = port_can_priority[`IPL_POS_PF+:2]; // R9
   assign can_msg_buffer_level = port_can_priority[`IPL_POS_CANMB+:2]; // R10
   assign can_wakeup_level = port_can_priority[`IPL_POS_CANWK+:2]; // R10
   assign can_error_level = port_can_priority[`IPL_POS_CANERR+:2]; // R10
   assign can_bus_off_level = port_can_priority[`IPL_POS_CANBOFF+:2]; // R10
   assign per_fields[25:24] = port_d_level;
   assign per_fields[23:22] = port_e_level;
   assign per_fields[21:20] = port_f_level;
   assign per_fields[19:18] = can_msg_buffer_level;
   assign per_fields[17:16] = can_wakeup_level;
   assign per_fields[15:14] = can_error_level;
   assign per_fields[13:12] = can_bus_off_level;

   // ----------------------------------------
   // serial and port register fields
   // ----------------------------------------
   wire [1:0] spi_zero_rx_full_level;
   wire [1:0] spi_one_tx_empty_level;
   wire [1:0] spi_one_rx_full_level;
   wire [1:0] port_a_level;
   wire [1:0] port_b_level;
   wire [1:0] port_c_level;
   assign spi_zero_rx_full_level = serial_port_priority[`IPL_POS_SPI0RX+:2]; // R11
   assign spi_one_tx_empty_level = serial_port_priority[`IPL_POS_SPI1TX+:2]; // R11
   assign spi_one_rx_full_level = serial_port_priority[`IPL_POS_SPI1RX+:2]; // R11
   assign port_a_level = serial_port_priority[`IPL_POS_PA+:2]; // R12
   assign port_b_level = serial_port_priority[`IPL_POS_PB+:2]; // R12
   assign port_c_level = serial_port_priority[`IPL_POS_PC+:2]; // R13
   assign per_fields[11:10] = spi_zero_rx_full_level;
   assign per_fields[9:8] = spi_one_tx_empty_level;
   assign per_fields[7:6] = spi_one_rx_full_level;
   assign per_fields[5:4] = port_a_level;
   assign per_fields[3:2] = port_b_level;
   assign per_fields[1:0] = port_c_level;

   // ----------------------------------------
   // decode per source
   // ----------------------------------------
   // the highest index of each vector is the first source in the lists above
   wire [`IPL_NUM_DEBUG-1:0] dbg_req_c;
   wire [2*`IPL_NUM_DEBUG-1:0] dbg_lvl_c;
   wire [`IPL_NUM_PERIPH-1:0] per_req_c;
   wire [2*`IPL_NUM_PERIPH-1:0] per_lvl_c;

   genvar i;
   generate
      for (i = 0; i < `IPL_NUM_DEBUG; i = i + 1) begin : g_dbg
         ipl_decode #(.DEBUG(1)) u_dec ( // R1
            .field(dbg_fields[2*i+:2]),
            .pending(dbg_pending[i]),
            .request(dbg_req_c[i]),
            .level(dbg_lvl_c[2*i+:2])
         );
      end
   endgenerate

   // peripheral and pin sources sit one level below the debug sources
   generate
      for (i = 0; i < `IPL_NUM_PERIPH; i = i + 1) begin : g_per
         ipl_decode #(.DEBUG(0)) u_dec ( // R2
            .field(per_fields[2*i+:2]),
            .pending(per_pending[i]),
            .request(per_req_c[i]),
            .level(per_lvl_c[2*i+:2])
         );
      end
   endgenerate

   // ----------------------------------------
   // outputs to the arbiter
   // ----------------------------------------
   // registered so the arbiter sees stable data one cycle after a change
   always @(posedge clk) begin
      if (rst) begin
         dbg_request <= {`IPL_NUM_DEBUG{1'b0}};
         dbg_level <= {2*`IPL_NUM_DEBUG{1'b0}};
      end else begin
         dbg_request <= dbg_req_c; // R14
         dbg_level <= dbg_lvl_c; // R1
      end
   end

   // a field of 00 blocks its request whatever the source does
   always @(posedge clk) begin
      if (rst) begin
         per_request <= {`IPL_NUM_PERIPH{1'b0}};
         per_level <= {2*`IPL_NUM_PERIPH{1'b0}};
      end else begin
         per_request <= per_req_c; // R14
         per_level <= per_lvl_c; // R2
      end
   end
endmodule

// >>> hdl/ipl_map.vh
// register offsets, field positions and reset values of the priority registers
//
// What this block does
// [R1] debug fields: 00 off, 01 level 1, 10 level 2, 11 level 3
// [R2] peripheral and pin fields: 00 off, 01 level 0, 10 level 1, 11 level 2
// [R3] every priority field is 00 after reset, all sources disabled
// [R4] reserved bits read zero and ignore writes
// [R5] debug break register: breakpoint 13:12, step counter 11:10, 9:0 reserved
// [R6] debug transfer register: receive 5:4, transmit 3:2, trace 1:0
// [R7] system register: flash empty 15:14, command done 13:12, error 11:10
// [R8] system register: pll 9:8, low voltage 7:6, pin b 3:2, pin a 1:0
// [R9] port register: ports d, e, f at 15:14, 13:12, 11:10
// [R10] port register: can buffer 9:8, wakeup 7:6, error 5:4, bus off 3:2
// [R11] serial register: spi0 rx 15:14, spi1 tx 13:12, spi1 rx 11:10
// [R12] serial register: port a 5:4, port b 3:2
// [R13] serial register: port c 1:0, off or level 0 to 2
// [R14] decoded level goes to the arbiter; disabled source never requests
`ifndef IPL_MAP_VH
`define IPL_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define IPL_OFS_BREAK 3'h0
`define IPL_OFS_XFER 3'h1
`define IPL_OFS_SYSTEM 3'h2
`define IPL_OFS_PORT 3'h3
`define IPL_OFS_SERIAL 3'h4

// ----------------------------------------
// writable bit masks and reset value
// ----------------------------------------
`define IPL_MASK_BREAK 16'h3C00
`define IPL_MASK_XFER 16'h003F
`define IPL_MASK_SYSTEM 16'hFFCF
`define IPL_MASK_PORT 16'hFFFC
`define IPL_MASK_SERIAL 16'hFC3F
`define IPL_RESET 16'h0000

// ----------------------------------------
// field low bit positions
// ----------------------------------------
`define IPL_POS_BKPT 12
`define IPL_POS_STEP 10
`define IPL_POS_DRX 4
`define IPL_POS_DTX 2
`define IPL_POS_TRACE 0
`define IPL_POS_FLEMPTY 14
`define IPL_POS_FLDONE 12
`define IPL_POS_FLERR 10
`define IPL_POS_PLL 8
`define IPL_POS_LVD 6
`define IPL_POS_PINB 2
`define IPL_POS_PINA 0
`define IPL_POS_PD 14
`define IPL_POS_PE 12
`define IPL_POS_PF 10
`define IPL_POS_CANMB 8
`define IPL_POS_CANWK 6
`define IPL_POS_CANERR 4
`define IPL_POS_CANBOFF 2
`define IPL_POS_SPI0RX 14
`define IPL_POS_SPI1TX 12
`define IPL_POS_SPI1RX 10
`define IPL_POS_PA 4
`define IPL_POS_PB 2
`define IPL_POS_PC 0

// ----------------------------------------
// source counts
// ----------------------------------------
`define IPL_NUM_DEBUG 5
`define IPL_NUM_PERIPH 20

`endif

// >>> hdl/ipl_reg16.v
// one 16-bit priority register with a fixed writable mask
`timescale 1ns/1ps
`include "ipl_map.vh"
module ipl_reg16 #(
   parameter [15:0] MASK = 16'hFFFF
) (
   clk,
   rst,
   wr,
   wdata,
   q
);
   input wire clk;
   input wire rst;
   input wire wr;
   input wire [15:0] wdata;
   output reg [15:0] q;

   always @(posedge clk) begin
      if (rst) begin
         q <= `IPL_RESET; // R3
      end else if (wr) begin
         // reserved bits never store, so they read as zero
         q <= wdata & MASK; // R4
      end
   end
endmodule

// >>> hdl/ipl_decode.v
// decodes one two-bit priority field into a request and a level
`timescale 1ns/1ps
module ipl_decode #(
   parameter DEBUG = 0
) (
   field,
   pending,
   request,
   level
);
   input wire [1:0] field;
   input wire pending;
   output wire request;
   output wire [1:0] level;

   // debug sources sit one level higher: 01 maps to level 1 instead of 0
   assign level = (DEBUG != 0) ? field : (field - 2'h1); // R1 R2
   assign request = pending & (field != 2'h0); // R14
endmodule

// >>> bench/ipl_src_model.sv
// stand-in for the interrupt sources that drive the pending lines
`timescale 1ns/1ps
module ipl_src_model (
   input wire clk,
   input wire all_on,
   output reg [4:0] dbg_pending,
   output reg [19:0] per_pending
);
   initial begin
      dbg_pending = 5'h00;
      per_pending = 20'h00000;
   end
   // sources are same-clock logic, so they only move just after an edge
   always @(posedge clk) begin
      dbg_pending <= all_on ? 5'h1F : 5'h15;
      per_pending <= all_on ? 20'hFFFFF : 20'h5A5A5;
   end
endmodule

// >>> bench/ipl_regs_props.sv
// assertions on the ports of the priority register block
`timescale 1ns/1ps
module ipl_regs_props (
   input wire clk,
   input wire rst,
   input wire [2:0] addr,
   input wire [15:0] wdata,
   input wire wr,
   input wire rd,
   input wire [15:0] rdata,
   input wire [4:0] dbg_pending,
   input wire [19:0] per_pending,
   input wire [4:0] dbg_request,
   input wire [9:0] dbg_level,
   input wire [19:0] per_request,
   input wire [39:0] per_level
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_idle; !$past(rd) |-> rdata == 16'h0000; endproperty
   a_idle: assert property (p_idle) else $error("rdata set without read");
   property p_unmap; rd && addr > 3'h4 |=> rdata == 16'h0000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
   property p_brk; rd && addr == 3'h0 |=> (rdata & 16'hC3FF) == 16'h0000; endproperty
   a_brk: assert property (p_brk) else $error("break reserved set");
   property p_sys; rd && addr == 3'h2 |=> rdata[5:4] == 2'h0; endproperty
   a_sys: assert property (p_sys) else $error("system reserved set");
   property p_ser; rd && addr == 3'h4 |=> rdata[9:6] == 4'h0; endproperty
   a_ser: assert property (p_ser) else $error("serial reserved set");
   // a request may only follow a pending source one edge late
   property p_dreq; (dbg_request & ~$past(dbg_pending)) == 5'h00; endproperty
   a_dreq: assert property (p_dreq) else $error("debug request unpending");
   property p_preq; (per_request & ~$past(per_pending)) == 20'h00000; endproperty
   a_preq: assert property (p_preq) else $error("request unpending");
   property p_trace;
      wr && addr == 3'h1 ##1 !(wr && addr == 3'h1) |=>
         dbg_level[1:0] == $past(wdata[1:0], 2);
   endproperty
   a_trace: assert property (p_trace) else $error("trace level wrong");
   property p_portc;
      wr && addr == 3'h4 && wdata[1:0] != 2'h0 ##1 !(wr && addr == 3'h4) |=>
         per_level[1:0] == $past(wdata[1:0], 2) - 2'h1 && per_request[0] == $past(per_pending[0]);
   endproperty
   a_portc: assert property (p_portc) else $error("port c level wrong");
endmodule
bind ipl_regs ipl_regs_props ipl_regs_props_inst (.clk, .rst, .addr, .wdata, .wr, .rd,
   .rdata, .dbg_pending, .per_pending, .dbg_request, .dbg_level, .per_request, .per_level);

// >>> bench/ipl_regs_test.sv
// self-checking bench for the priority register block
`timescale 1ns/1ps
module ipl_regs_test;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [2:0] addr = 3'h0;
   reg [15:0] wdata = 16'h0000;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg all_on = 1'b1;
   wire [15:0] rdata;
   wire [4:0] dbg_pending;
   wire [4:0] dbg_request;
   wire [19:0] per_pending;
   wire [19:0] per_request;
   wire [9:0] dbg_level;
   wire [39:0] per_level;
   integer n_mismatch = 0;
   integer comparisons = 0;
   integer cycles = 0;
   integer i;
   always #4 clk = ~clk;
   ipl_src_model ipl_src_model_inst (.clk, .all_on, .dbg_pending, .per_pending);
   ipl_regs ipl_regs_inst (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .dbg_pending,
      .per_pending, .dbg_request, .dbg_level, .per_request, .per_level);
   task conclude;
      begin
         if (n_mismatch == 0 && comparisons > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input [39:0] got, input [39:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // an idle edge after each strobe keeps one assignment per signal per step
   task wr_reg(input [2:0] a, input [15:0] d);
      begin
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rd_reg(input [2:0] a, input [15:0] exp);
      begin
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1 chk(rdata, exp);
         @(posedge clk);
      end
   endtask
   function [15:0] mask_of(input [2:0] a);
      case (a)
         3'h0: mask_of = 16'h3C00;
         3'h1: mask_of = 16'h003F;
         3'h2: mask_of = 16'hFFCF;
         3'h3: mask_of = 16'hFFFC;
         3'h4: mask_of = 16'hFC3F;
         default: mask_of = 16'h0000;
      endcase
   endfunction
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 1000) begin
         n_mismatch = n_mismatch + 1;
         conclude;
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 8; i = i + 1) rd_reg(i[2:0], 16'h0000);
      chk({dbg_request, per_request}, 25'h0000000);
      for (i = 0; i < 8; i = i + 1) wr_reg(i[2:0], 16'hFFFF);
      for (i = 0; i < 8; i = i + 1) rd_reg(i[2:0], mask_of(i[2:0]));
      chk({dbg_request, per_request, dbg_level}, {25'h1FFFFFF, 10'h3FF});
      chk(per_level, 40'hAAAAAAAAAA);
      // distinct codes per field so a shifted field shows up
      wr_reg(3'h0, 16'h2C00);
      wr_reg(3'h1, 16'h001B);
      wr_reg(3'h2, 16'hE787);
      wr_reg(3'h3, 16'h6DB4);
      wr_reg(3'h4, 16'hD82D);
      all_on <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(dbg_level, 10'h2DB);
      chk(per_level, 40'h9248618858);
      chk({dbg_request, per_request}, {5'h15, 20'h5A5A5});
      @(posedge clk);
      wr_reg(3'h0, 16'h0000);
      wr_reg(3'h2, 16'h0000);
      #1 chk({dbg_request, per_request}, {5'h05, 20'h005A5});
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 5; i = i + 1) rd_reg(i[2:0], 16'h0000);
      chk({dbg_request, per_request}, 25'h0000000);
      conclude;
   end
endmodule
